// >>> hw/sdmap_params.svh
// Constants for the SDRAM access address mapper.
`ifndef SDMAP_PARAMS_SVH
`define SDMAP_PARAMS_SVH
`define SDMAP_NUM_CS        4
`define SDMAP_ADDR_W        15
`define SDMAP_AP_BIT        10
`define SDMAP_BA1_PIN       14
`define SDMAP_BA0_PIN       13
`define SDMAP_BURST_16      4'h8
`define SDMAP_BURST_32      4'h4
`define SDMAP_HSIZE_WORD    3'h2
`define SDMAP_HRESP_OKAY    2'h0
`define SDMAP_HRESP_ERROR   2'h1
`define SDMAP_CFG_W         8
`define SDMAP_CFG_WP_BIT    7
`define SDMAP_CFG_W16_BIT   6
`define SDMAP_CFG_AM_HI     2
`define SDMAP_CFG_AM_LO     0
`define SDMAP_AM_W          3
`endif

// >>> hw/sdmap_pkg.sv
// Types for the SDRAM access address mapper.
package sdmap_pkg;
  typedef enum logic [2:0] {
    SDMAP_AM_RBC_1MX16  = 3'h0,
    SDMAP_AM_RBC_2MX8   = 3'h1,
    SDMAP_AM_RBC_8MX16  = 3'h2,
    SDMAP_AM_RBC_16MX8  = 3'h3,
    SDMAP_AM_RBC_8MX32  = 3'h4,
    SDMAP_AM_BRC_1MX16  = 3'h5
  } sdmap_map_t;
  typedef enum logic [2:0] {
    SDMAP_IDLE = 3'b000,
    SDMAP_ROW  = 3'b011,
    SDMAP_COL  = 3'b010,
    SDMAP_WAIT = 3'b001,
    SDMAP_ERR1 = 3'b100,
    SDMAP_ERR2 = 3'b101
  } sdmap_state_t;
endpackage

// >>> hw/sdmap_top.sv
// AHB to SDRAM row, bank and column address mapper.
`timescale 1ns/1ps
`include "sdmap_params.svh"
// Notes on behaviour
// - Each dynamic chip select has its own write-protect configuration bit.
// - Writes to protected chip selects get AHB ERROR and are not performed.
// - Narrow chip selects stall AHB; the two halfword column reads of one transfer are assembled into one word.
// - Transfers wider than a word get an AHB ERROR response.
// - The address-map field of each chip select picks its address mapping.
// - Auto-precharge flag is driven on A10 in every column phase.
// - Burst length is 8 for 16-bit devices, 4 for 32-bit devices.
// - 32-bit 1Mx16 ROW_BANK_COLUMN_ORDER: row 21..11, BA0=bit 10, column 9..2.
// - 32-bit 2Mx8 ROW_BANK_COLUMN_ORDER: row 22..12, BA1=bit 11, column 10..2.
// - 32-bit 8Mx16 ROW_BANK_COLUMN_ORDER: row 24..13, BA1=11, BA0=12, column 10..2.
// - 32-bit 16Mx8 ROW_BANK_COLUMN_ORDER: row 25..14, BA1=13, BA0=12, column 11..2.
// - 32-bit 8Mx32 ROW_BANK_COLUMN_ORDER: row 24..12, BA1=11, BA0=10, column 9..2.
// - 32-bit 1Mx16 BANK_ROW_COLUMN_ORDER: BA1=bit 21, row 20..10, column 9..2.
// - 16-bit chip selects do two column transfers, lowest column bit 0 then 1.
module sdmap_top
  import sdmap_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Per chip select configuration
  input  wire logic [`SDMAP_CFG_W*`SDMAP_NUM_CS-1:0] dynamic_chip_config,
  // AHB slave
  input  wire logic                          hsel,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    hcs,
  input  wire logic [31:0]                   hwdata,
  output logic                               hready_out,
  output logic [1:0]                         hresp,
  output logic [31:0]                        hrdata,
  // SDRAM side
  output logic [`SDMAP_ADDR_W-1:0]           sd_addr,
  output logic                               sd_row_phase,
  output logic                               sd_col_phase,
  output logic                               sd_write,
  output logic [3:0]                         sd_burst_len,
  output logic [1:0]                         sd_cs,
  output logic [31:0]                        sd_wdata,
  input  wire logic [31:0]                   sd_rdata,
  input  wire logic                          sd_done
);
  // ----------------------------------------------------------------
  // Address mapping functions
  // ----------------------------------------------------------------
  function automatic logic [`SDMAP_ADDR_W-1:0] map_row(input logic [2:0] am, input logic [31:0] a);
    logic [`SDMAP_ADDR_W-1:0] r;
    r = '0;
    case (am)
      SDMAP_AM_RBC_1MX16: begin
        r[10:0] = a[21:11];
        r[`SDMAP_BA0_PIN] = a[10];
      end
      SDMAP_AM_RBC_2MX8: begin
        r[10:0] = a[22:12];
        r[`SDMAP_BA1_PIN] = a[11];
      end
      SDMAP_AM_RBC_8MX16: begin
        r[11:0] = a[24:13];
        r[`SDMAP_BA1_PIN] = a[11];
        r[`SDMAP_BA0_PIN] = a[12];
      end
      SDMAP_AM_RBC_16MX8: begin
        r[11:0] = a[25:14];
        r[`SDMAP_BA1_PIN] = a[13];
        r[`SDMAP_BA0_PIN] = a[12];
      end
      SDMAP_AM_RBC_8MX32: begin
        r[12:0] = a[24:12];
        r[`SDMAP_BA1_PIN] = a[11];
        r[`SDMAP_BA0_PIN] = a[10];
      end
      SDMAP_AM_BRC_1MX16: begin
        r[10:0] = a[20:10];
        r[`SDMAP_BA1_PIN] = a[21];
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  // Bank pins reuse the row-phase function so both phases can never differ.
  function automatic logic [`SDMAP_ADDR_W-1:0] map_col(input logic [2:0] am, input logic [31:0] a,
                                                      input logic w16, input logic hi);
    logic [`SDMAP_ADDR_W-1:0] c;
    logic [`SDMAP_ADDR_W-1:0] r;
    c = '0;
    r = map_row(am, a);
    c[`SDMAP_BA1_PIN] = r[`SDMAP_BA1_PIN];
    c[`SDMAP_BA0_PIN] = r[`SDMAP_BA0_PIN];
    case (am)
      SDMAP_AM_RBC_2MX8, SDMAP_AM_RBC_8MX16: c[8:0] = a[10:2];
      SDMAP_AM_RBC_16MX8:                    c[9:0] = a[11:2];
      default:                               c[7:0] = a[9:2];
    endcase
    c[`SDMAP_AP_BIT] = 1'b1;
    // Narrow chip selects keep the column and put the half index on the lowest pin.
    if (w16) begin
      c[0] = hi;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  logic [`SDMAP_CFG_W-1:0] cfg;
  logic                    req;
  assign cfg = dynamic_chip_config[hcs*`SDMAP_CFG_W +: `SDMAP_CFG_W];
  assign req = hsel && htrans[1] && hready_out;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sdmap_state_t state_reg, state_next;
  logic [31:0]  addr_reg, addr_next;
  logic [2:0]   am_reg, am_next;
  logic         w16_reg, w16_next;
  logic         half_reg, half_next;
  logic         wr_reg, wr_next;
  logic [1:0]   cs_reg, cs_next;
  logic [31:0]  wdat_reg, wdat_next;
  logic         ready_reg, ready_next;
  logic [1:0]   resp_reg, resp_next;
  logic [`SDMAP_ADDR_W-1:0] sda_reg, sda_next;
  logic         rowp_reg, rowp_next, colp_reg, colp_next;
  logic [3:0]   bl_reg, bl_next;
  logic         wb_lo, wb_hi, wb_full;

  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    am_next    = am_reg;
    w16_next   = w16_reg;
    half_next  = half_reg;
    wr_next    = wr_reg;
    cs_next    = cs_reg;
    wdat_next  = wdat_reg;
    ready_next = ready_reg;
    resp_next  = `SDMAP_HRESP_OKAY;
    sda_next   = sda_reg;
    rowp_next  = 1'b0;
    colp_next  = 1'b0;
    bl_next    = bl_reg;
    wb_lo      = 1'b0;
    wb_hi      = 1'b0;
    wb_full    = 1'b0;
    case (state_reg)
      SDMAP_IDLE: begin
        if (req) begin
          if (hsize > `SDMAP_HSIZE_WORD || (hwrite && cfg[`SDMAP_CFG_WP_BIT])) begin
            ready_next = 1'b0;
            resp_next  = `SDMAP_HRESP_ERROR;
            state_next = SDMAP_ERR1;
          end else begin
            addr_next  = haddr;
            am_next    = cfg[`SDMAP_CFG_AM_HI:`SDMAP_CFG_AM_LO];
            w16_next   = cfg[`SDMAP_CFG_W16_BIT];
            wr_next    = hwrite;
            cs_next    = hcs;
            half_next  = 1'b0;
            ready_next = 1'b0;
            state_next = SDMAP_WAIT;
          end
        end
      end
      SDMAP_WAIT: begin
        // Write data arrives one cycle after the address phase.
        wdat_next  = hwdata;
        sda_next   = map_row(am_reg, addr_reg);
        rowp_next  = 1'b1;
        bl_next    = w16_reg ? `SDMAP_BURST_16 : `SDMAP_BURST_32;
        state_next = SDMAP_ROW;
      end
      SDMAP_ROW: begin
        if (sd_done) begin
          sda_next = map_col(am_reg, addr_reg, w16_reg, half_reg);
          colp_next  = 1'b1;
          state_next = SDMAP_COL;
        end else begin
          rowp_next = 1'b1;
        end
      end
      SDMAP_COL: begin
        if (sd_done) begin
          wb_full = !w16_reg && !wr_reg;
          wb_lo   = w16_reg && !wr_reg && !half_reg;
          wb_hi   = w16_reg && !wr_reg && half_reg;
          if (w16_reg && !half_reg) begin
            half_next  = 1'b1;
            sda_next   = map_col(am_reg, addr_reg, w16_reg, 1'b1);
            // The high half moves down so the write data pin still comes from a register.
            wdat_next  = {16'h0, wdat_reg[31:16]};
            colp_next  = 1'b1;
          end else begin
            ready_next = 1'b1;
            state_next = SDMAP_IDLE;
          end
        end else begin
          colp_next = 1'b1;
        end
      end
      SDMAP_ERR1: begin
        resp_next  = `SDMAP_HRESP_ERROR;
        ready_next = 1'b1;
        // Idle during the second error cycle, so a transfer offered then is not lost.
        state_next = SDMAP_IDLE;
      end
      SDMAP_ERR2: begin
        state_next = SDMAP_IDLE;
      end
      default: state_next = SDMAP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= SDMAP_IDLE;
      addr_reg  <= 32'h0;
      am_reg    <= 3'h0;
      w16_reg   <= 1'b0;
      half_reg  <= 1'b0;
      wr_reg    <= 1'b0;
      cs_reg    <= 2'h0;
      wdat_reg  <= 32'h0;
      ready_reg <= 1'b1;
      resp_reg  <= `SDMAP_HRESP_OKAY;
      sda_reg   <= '0;
      rowp_reg  <= 1'b0;
      colp_reg  <= 1'b0;
      bl_reg    <= `SDMAP_BURST_32;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      am_reg    <= am_next;
      w16_reg   <= w16_next;
      half_reg  <= half_next;
      wr_reg    <= wr_next;
      cs_reg    <= cs_next;
      wdat_reg  <= wdat_next;
      ready_reg <= ready_next;
      resp_reg  <= resp_next;
      sda_reg   <= sda_next;
      rowp_reg  <= rowp_next;
      colp_reg  <= colp_next;
      bl_reg    <= bl_next;
    end
  end

  // ----------------------------------------------------------------
  // Read word assembly
  // ----------------------------------------------------------------
  sdmap_word_buf u_buf (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_lo   (wb_lo),
    .wr_hi   (wb_hi),
    .wr_full (wb_full),
    .wr_data (sd_rdata),
    .rd_data (hrdata)
  );

  assign hready_out   = ready_reg;
  assign hresp        = resp_reg;
  assign sd_addr      = sda_reg;
  assign sd_row_phase = rowp_reg;
  assign sd_col_phase = colp_reg;
  assign sd_write     = wr_reg;
  assign sd_burst_len = bl_reg;
  assign sd_cs        = cs_reg;
  // A 16-bit bus sends the low half first, then the high half.
  assign sd_wdata     = wdat_reg;
endmodule

// >>> hw/sdmap_word_buf.sv
// Small register that assembles two halfwords into one word.
`timescale 1ns/1ps
`include "sdmap_params.svh"
module sdmap_word_buf
  import sdmap_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write side
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic        wr_full,
  input  wire logic [31:0] wr_data,
  // Read side
  output logic      [31:0] rd_data
);
  logic [31:0] word_reg;
  logic [31:0] word_next;

  always_comb begin
    word_next = word_reg;
    if (wr_full) begin
      word_next = wr_data;
    end else if (wr_lo) begin
      word_next[15:0] = wr_data[15:0];
    end else if (wr_hi) begin
      word_next[31:16] = wr_data[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      word_reg <= 32'h0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign rd_data = word_reg;
endmodule

// >>> tb/sdmap_checker_assertions.sv
// Port-level checker for the SDRAM access address mapper.
`timescale 1ns/1ps
`include "sdmap_params.svh"
module sdmap_checker
  import sdmap_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Configuration and AHB side
  input wire logic [31:0] dynamic_chip_config,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [1:0]  hcs,
  input wire logic        hready_out,
  input wire logic [1:0]  hresp,
  // SDRAM side
  input wire logic [14:0] sd_addr,
  input wire logic        sd_row_phase,
  input wire logic        sd_col_phase,
  input wire logic [3:0]  sd_burst_len,
  input wire logic [1:0]  sd_cs
);
  logic       take;
  logic [1:0] bank_reg;
  assign take = hsel && htrans[1] && hready_out;
  always_ff @(posedge clk) bank_reg <= sd_row_phase ? sd_addr[14:13] : bank_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wide_err: assert property (take && hsize > `SDMAP_HSIZE_WORD
    |=> !hready_out && hresp == `SDMAP_HRESP_ERROR) else $error("wide transfer not refused");
  a_prot_err: assert property (take && hwrite && dynamic_chip_config[8*hcs+`SDMAP_CFG_WP_BIT]
    |=> !hready_out && hresp == `SDMAP_HRESP_ERROR) else $error("protected write not refused");
  a_err_quiet: assert property (hresp == `SDMAP_HRESP_ERROR |-> !sd_row_phase && !sd_col_phase)
    else $error("SDRAM activity during error");
  a_err_span: assert property (!hready_out && hresp == `SDMAP_HRESP_ERROR
    |=> hready_out && hresp == `SDMAP_HRESP_ERROR ##1 (hresp == `SDMAP_HRESP_OKAY || !hready_out))
    else $error("bad error span");
  a_ap_col: assert property (sd_col_phase |-> sd_addr[`SDMAP_AP_BIT]) else $error("precharge flag low");
  a_burst_len: assert property (sd_row_phase |-> sd_burst_len == (dynamic_chip_config[8*sd_cs+`SDMAP_CFG_W16_BIT]
    ? `SDMAP_BURST_16 : `SDMAP_BURST_32)) else $error("wrong burst length");
  a_bank_hold: assert property ($rose(sd_col_phase) |-> sd_addr[14:13] == bank_reg)
    else $error("bank changed between phases");
  a_bus_stall: assert property (sd_row_phase || sd_col_phase |-> !hready_out) else $error("bus not stalled");
endmodule
bind sdmap_top sdmap_checker chk_i (.clk, .rst_n, .dynamic_chip_config, .hsel, .htrans, .hwrite, .hsize, .hcs,
  .hready_out, .hresp, .sd_addr, .sd_row_phase, .sd_col_phase, .sd_burst_len, .sd_cs);

// >>> tb/sdmap_sdram_model.sv
// Behavioural SDRAM that ends each address phase with a done pulse.
`timescale 1ns/1ps
module sdmap_sdram_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Phase requests
  input  wire logic        row_phase,
  input  wire logic        col_phase,
  input  wire logic [14:0] addr,
  input  wire logic        slow,
  // Answer
  output logic             done,
  output logic      [31:0] rdata
);
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  logic        done_next;
  logic [31:0] rd_next;
  always_comb begin
    cnt_next  = 3'h0;
    done_next = 1'b0;
    // Outside a column the data toggles, so a stale word is never mistaken for fresh.
    rd_next   = col_phase ? ({17'h0, addr} ^ 32'h5A5A3C3C) : ~rdata;
    if ((row_phase || col_phase) && !done) begin
      done_next = (cnt_reg == (slow ? 3'h5 : 3'h0));
      cnt_next  = done_next ? 3'h0 : cnt_reg + 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    cnt_reg <= rst_n ? cnt_next : 3'h0;
    done    <= rst_n ? done_next : 1'b0;
    rdata   <= rd_next;
  end
endmodule

// >>> tb/sdram_access_address_mapper_tb_top.sv
// Self-checking testbench for the SDRAM access address mapper.
`timescale 1ns/1ps
`include "sdmap_params.svh"
module sdram_access_address_mapper_tb_top
  import sdmap_pkg::*;
;
  logic        clk, rst_n, hsel, hwrite, hready_out, sd_row_phase, sd_col_phase, sd_done, slow, sd_write, wr_q;
  logic [31:0] cfg, haddr, hwdata, hrdata, sd_rdata, rd, sd_wdata;
  logic [1:0]  htrans, hcs, hresp, sd_cs, rsp, cs_q;
  logic [2:0]  hsize;
  logic [3:0]  sd_burst_len, bl;
  logic [14:0] sd_addr, row_q;
  logic [14:0] cols[$];
  logic [31:0] wds[$];
  int          error_cnt, compares;
  sdmap_top dut (.clk, .rst_n, .dynamic_chip_config(cfg), .hsel, .htrans, .hwrite, .hsize, .haddr, .hcs, .hwdata,
    .hready_out, .hresp, .hrdata, .sd_addr, .sd_row_phase, .sd_col_phase, .sd_write, .sd_burst_len, .sd_cs,
    .sd_wdata, .sd_rdata, .sd_done);
  sdmap_sdram_model sdram (.clk, .rst_n, .row_phase(sd_row_phase), .col_phase(sd_col_phase), .addr(sd_addr),
    .slow, .done(sd_done), .rdata(sd_rdata));
  function automatic logic [29:0] emap(input logic [2:0] m, input logic [31:0] a);
    case (m)
      3'h0: return {1'b0, a[10], 2'h0, a[21:11], 1'b0, a[10], 5'h0, a[9:2]};
      3'h1: return {a[11], 3'h0, a[22:12], a[11], 5'h0, a[10:2]};
      3'h2: return {a[11], a[12], 1'b0, a[24:13], a[11], a[12], 4'h0, a[10:2]};
      3'h3: return {a[13], a[12], 1'b0, a[25:14], a[13], a[12], 3'h0, a[11:2]};
      3'h4: return {a[11], a[10], a[24:12], a[11], a[10], 5'h0, a[9:2]};
      default: return {a[21], 3'h0, a[20:10], a[21], 6'h0, a[9:2]};
    endcase
  endfunction
  function automatic logic [31:0] md(input logic [14:0] c);
    return {17'h0, c} ^ 32'h5A5A3C3C;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic w, input logic [2:0] sz, input logic [31:0] a, input logic [1:0] c);
    int n;
    n = 0;
    cols.delete();
    wds.delete();
    @(negedge clk);
    hsel = 1'b1;
    htrans = 2'h2;
    hwrite = w;
    hsize = sz;
    haddr = a;
    hcs = c;
    @(negedge clk);
    hsel = 1'b0;
    htrans = 2'h0;
    hwdata = ~a;
    while (hready_out !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    rsp = hresp;
    rd = hrdata;
  endtask
  task automatic wrap_up;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_maps;
    logic [29:0] e;
    for (int m = 0; m < 6; m++) begin
      cfg = {29'h0, m[2:0]};
      slow = m[0];
      e = emap(m[2:0], 32'h0355A6B4);
      req(1'b0, 3'h2, 32'h0355A6B4, 2'h0);
      chk(row_q, e[29:15]);
      chk(cols.size(), 1);
      chk(cols[0], e[14:0] | 15'h0400);
      chk(bl, 4'h4);
      chk(rd, md(e[14:0] | 15'h0400));
      chk(cs_q, 2'h0);
    end
    $display("address map test done");
  endtask
  task automatic t_narrow;
    logic [14:0] c;
    logic [29:0] e;
    logic [31:0] lo, hi;
    cfg = 32'h00004000;
    e = emap(3'h0, 32'h0012345C);
    c = e[14:0] | 15'h0400;
    lo = md(c & 15'h7FFE);
    hi = md(c | 15'h0001);
    req(1'b0, 3'h2, 32'h0012345C, 2'h1);
    chk(cols.size(), 2);
    chk(cols[0], c & 15'h7FFE);
    chk(cols[1], c | 15'h0001);
    chk(bl, 4'h8);
    chk(rd, {hi[15:0], lo[15:0]});
    req(1'b1, 3'h2, 32'h0012345C, 2'h1);
    chk(wds.size(), 2);
    chk(wds[0][15:0], 16'hCBA3);
    chk(wds[1][15:0], 16'hFFED);
    chk(cs_q, 2'h1);
    chk(wr_q, 1'b1);
    $display("narrow bus test done");
  endtask
  task automatic t_err;
    cfg = 32'h00800000;
    req(1'b1, 3'h2, 32'h00001000, 2'h2);
    chk(rsp, `SDMAP_HRESP_ERROR);
    chk(cols.size(), 0);
    req(1'b0, 3'h2, 32'h00001000, 2'h2);
    chk(rsp, `SDMAP_HRESP_OKAY);
    req(1'b1, 3'h2, 32'h00001000, 2'h0);
    chk(rsp, `SDMAP_HRESP_OKAY);
    chk(wds[0], 32'hFFFFEFFF);
    chk(wr_q, 1'b1);
    req(1'b0, 3'h3, 32'h00001000, 2'h0);
    chk(rsp, `SDMAP_HRESP_ERROR);
    chk(cols.size(), 0);
    $display("error test done");
  endtask
  always @(posedge clk) begin
    if (sd_done && sd_row_phase) begin
      row_q <= sd_addr;
      bl <= sd_burst_len;
    end
    if (sd_done && sd_col_phase) begin
      cols.push_back(sd_addr);
      wds.push_back(sd_wdata);
      wr_q <= sd_write;
      cs_q <= sd_cs;
    end
  end
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #500000;
    error_cnt++;
    wrap_up;
  end
  initial begin
    {rst_n, hsel, hwrite, slow, htrans, hcs, haddr, hwdata, cfg} = '0;
    hsize = 3'h2;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_maps;
    t_narrow;
    t_err;
    wrap_up;
  end
endmodule
